// File: cpu_register_datapath.sv
// Register datapath: accumulators, index registers, program counter
// and the transient registers that move words between them.
// Assumes storage and channels answer within the cycle of the strobe.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_datapath
   import datapath_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // Command port
   input  wire logic              cmd_valid,
   input  wire command_type       cmd,
   output logic                   cmd_ready,
   output logic                   busy,
   // Instruction and storage
   input  wire logic              instr_load,
   input  wire logic [WORD_W-1:0] instr_word,
   input  wire logic              modify_en,
   input  wire logic              read_strobe,
   input  wire logic [WORD_W-1:0] sense_data,
   input  wire logic              write_strobe,
   output logic      [ADDR_W-1:0] storage_addr,
   output logic      [WORD_W-1:0] write_data,
   // Input channel
   input  wire logic              chan_in_valid,
   input  wire logic [WORD_W-1:0] chan_in_data,
   // Output channels
   input  wire logic              periph_out_load,
   input  wire logic              intercomp_out_load,
   output logic      [WORD_W-1:0] peripheral_output_buffer,
   output logic      [WORD_W-1:0] intercomputer_output_buffer,
   // Visible state
   output visible_type            visible
);

////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      IDLE  = 3'b001,
      MUL   = 3'b010,
      DIV   = 3'b100
   } state_type;

   state_type          state;
   logic [WORD_W-1:0]  main_acc;
   logic [WORD_W-1:0]  aux_acc;
   logic [ADDR_W-1:0]  index_reg [1:INDEX_N];
   logic [ADDR_W-1:0]  program_addr;
   logic [WORD_W-1:0]  exchange;
   logic [ADDR_W-1:0]  addr_holder;
   logic [WORD_W-1:0]  operand_buf;
   logic [WORD_W-1:0]  instr_reg;
   logic [ADDR_W-1:0]  index_in;
   logic [ADDR_W-1:0]  index_out;
   logic [WORD_W-1:0]  adder_operand;
   logic [ADDR_W-1:0]  modified_addr;
   logic [STEP_W-1:0]  step_count;
   logic               step_done;
   logic               count_load;
   logic [STEP_W-1:0]  count_preset;
   logic               count_step;
   logic [OP_W-1:0]    shift_op;
   logic               shifting;
   logic [2*WORD_W-1:0] double_acc;
   logic [WORD_W:0]    partial;
   logic [WORD_W:0]    trial;
   logic               take;

   assign double_acc = {main_acc, aux_acc};
   assign cmd_ready  = (state == IDLE) && !shifting;
   assign busy       = !cmd_ready;
   assign take       = cmd_valid && cmd_ready;

////////////////////////////////////////////////////////////////////////
   // Step counter and address adder
   always_comb begin
      count_load   = 1'b0;
      count_preset = cmd.count;
      if (take && (cmd.op == OP_MUL || cmd.op == OP_DIV)) begin
         count_load   = 1'b1;
         count_preset = MULDIV_PRESET;
      end else if (take && (cmd.op == OP_SHL_A || cmd.op == OP_SHR_A ||
                  cmd.op == OP_SHL_AQ || cmd.op == OP_SHR_AQ ||
                  cmd.op == OP_SHL_Q || cmd.op == OP_SHR_Q)) begin
         count_load   = 1'b1;
         count_preset = cmd.count;
      end
   end

   assign count_step = (state != IDLE) || shifting;

   step_counter u_step (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (count_load),
      .preset  (count_preset),
      .step    (count_step),
      .count   (step_count),
      .done    (step_done)
   );

   end_around_adder u_addr (
      .base      (instr_reg[FIELD_Y_HI:FIELD_Y_LO]),
      .increment (index_out),
      .sum       (modified_addr)
   );

////////////////////////////////////////////////////////////////////////
   // Outbound index: the increment; selector zero reads as zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_out <= ADDR_ZERO;
      end else if (instr_load) begin
         index_out <= (instr_word[FIELD_B_HI:FIELD_B_LO] == 3'h0) ?
                      ADDR_ZERO :
                      index_reg[instr_word[FIELD_B_HI:FIELD_B_LO]];
      end
   end

   // Instruction holding register with in-place address modification
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_reg <= WORD_ZERO;
      end else if (instr_load) begin
         instr_reg <= instr_word;
      end else if (modify_en) begin
         instr_reg[FIELD_Y_HI:FIELD_Y_LO] <= modified_addr;
      end
   end

   // Inbound index register and the index bank
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_in <= ADDR_ZERO;
      end else if (take && cmd.op == OP_LOAD_IDX) begin
         index_in <= cmd.jump_addr;
      end
   end

   logic idx_write;
   logic [SEL_W-1:0] idx_sel;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_write <= 1'b0;
         idx_sel   <= 3'h0;
      end else begin
         idx_write <= take && cmd.op == OP_LOAD_IDX && cmd.index_sel != 3'h0;
         idx_sel   <= cmd.index_sel;
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi <= INDEX_N; gi++) begin : g_index
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               index_reg[gi] <= ADDR_ZERO;
            end else if (idx_write && idx_sel == SEL_W'(gi)) begin
               index_reg[gi] <= index_in;
            end
         end
      end
   endgenerate

////////////////////////////////////////////////////////////////////////
   // Storage address holder, operand buffer and channel input
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_holder <= ADDR_ZERO;
      end else if (instr_load) begin
         addr_holder <= instr_word[FIELD_Y_HI:FIELD_Y_LO];
      end else if (modify_en) begin
         addr_holder <= modified_addr;
      end
   end
   assign storage_addr = addr_holder;

   // Read clears then sets in one edge: the old word never mixes in
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         operand_buf <= WORD_ZERO;
      end else if (chan_in_valid) begin
         operand_buf <= chan_in_data;
      end else if (read_strobe) begin
         operand_buf <= WORD_ZERO | sense_data;
      end
   end
   assign write_data = write_strobe ? operand_buf : WORD_ZERO;

   // Exchange and adder operand registers are transient
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         exchange      <= WORD_ZERO;
         adder_operand <= WORD_ZERO;
      end else if (read_strobe) begin
         exchange      <= sense_data;
         adder_operand <= sense_data;
      end else if (take) begin
         exchange      <= operand_buf;
         adder_operand <= operand_buf;
      end
   end

////////////////////////////////////////////////////////////////////////
   // Sequencer and shift latch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= IDLE;
         shifting <= 1'b0;
         shift_op <= OP_NOP;
      end else begin
         unique case (state)
            IDLE: begin
               if (take && cmd.op == OP_MUL) begin
                  state <= MUL;
               end else if (take && cmd.op == OP_DIV) begin
                  state <= DIV;
               end
            end
            MUL, DIV: begin
               if (step_count == 6'h01) begin
                  state <= IDLE;
               end
            end
            default: state <= IDLE;
         endcase
         if (count_load && cmd.op != OP_MUL && cmd.op != OP_DIV) begin
            shifting <= (cmd.count != 6'h00);
            shift_op <= cmd.op;
         end else if (shifting && step_count <= 6'h01) begin
            shifting <= 1'b0;
         end
      end
   end

   // Shift-add multiply and restoring divide steps
   always_comb begin
      partial = {1'b0, main_acc} +
                (aux_acc[0] ? {1'b0, adder_operand} : {1'b0, WORD_ZERO});
      trial   = {main_acc, aux_acc[WORD_W-1]} - {1'b0, adder_operand};
   end

////////////////////////////////////////////////////////////////////////
   // Accumulators
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_acc <= WORD_ZERO;
         aux_acc  <= WORD_ZERO;
      end else if (state == MUL) begin
         {main_acc, aux_acc} <= {partial, aux_acc[WORD_W-1:1]};
      end else if (state == DIV) begin
         if (!trial[WORD_W]) begin
            {main_acc, aux_acc} <= {trial[WORD_W-1:0],
                                    aux_acc[WORD_W-2:0], 1'b1};
         end else begin
            {main_acc, aux_acc} <= {double_acc[2*WORD_W-2:0], 1'b0};
         end
      end else if (shifting) begin
         unique case (shift_op)
            OP_SHL_A:  main_acc <= {main_acc[WORD_W-2:0], 1'b0};
            OP_SHR_A:  main_acc <= {main_acc[WORD_W-1], main_acc[WORD_W-1:1]};
            OP_SHL_Q:  aux_acc  <= {aux_acc[WORD_W-2:0], 1'b0};
            OP_SHR_Q:  aux_acc  <= {aux_acc[WORD_W-1], aux_acc[WORD_W-1:1]};
            OP_SHL_AQ: {main_acc, aux_acc} <= {double_acc[2*WORD_W-2:0],
                                               1'b0};
            OP_SHR_AQ: {main_acc, aux_acc} <= {double_acc[2*WORD_W-1],
                                    double_acc[2*WORD_W-1:1]};
            default: ;
         endcase
      end else if (take) begin
         unique case (cmd.op)
            OP_ADD:    main_acc <= main_acc + exchange;
            OP_SUB:    main_acc <= main_acc - exchange;
            OP_LOAD_A: main_acc <= exchange;
            OP_LOAD_Q: aux_acc  <= exchange;
            OP_ADD_Q:  aux_acc  <= aux_acc + exchange;
            OP_AND_Q:  aux_acc  <= aux_acc & exchange;
            // Product builds up in main, so an old value must not leak in
            OP_MUL:    main_acc <= WORD_ZERO;
            default: ;
         endcase
      end
   end

   // Program counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_addr <= ADDR_ZERO;
      end else if (take && cmd.jump) begin
         program_addr <= cmd.jump_addr;
      end else if (instr_load) begin
         program_addr <= program_addr + ADDR_ONE;
      end
   end

   // Output synchronizing buffers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_output_buffer    <= WORD_ZERO;
         intercomputer_output_buffer <= WORD_ZERO;
      end else begin
         if (periph_out_load) begin
            peripheral_output_buffer <= exchange;
         end
         if (intercomp_out_load) begin
            intercomputer_output_buffer <= exchange;
         end
      end
   end

   assign visible = '{double_hi: main_acc, double_lo: aux_acc,
                      program_addr: program_addr};

////////////////////////////////////////////////////////////////////////
   muldiv_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (take && cmd.op == OP_MUL) |=> busy [*8])
      else $error("multiply ended early");
   muldiv_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (take && cmd.op == OP_DIV) |-> ##[30:31] cmd_ready)
      else $error("divide did not end in time");
   count_max_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      step_count <= SHIFT_MAX)
      else $error("step count above limit");
   add_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (take && cmd.op == OP_ADD && !shifting) |=>
      main_acc == $past(main_acc) + $past(exchange))
      else $error("sum not kept");
   pc_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (instr_load && !(take && cmd.jump)) |=>
      program_addr == $past(program_addr) + ADDR_ONE)
      else $error("program counter did not step");
   sel_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (instr_load && instr_word[FIELD_B_HI:FIELD_B_LO] == 3'h0) |=>
      index_out == ADDR_ZERO)
      else $error("selector zero not zero");
   chan_in_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      chan_in_valid |=> operand_buf == $past(chan_in_data))
      else $error("channel word not buffered");
   idx_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !idx_write |=> $stable(index_reg[1]))
      else $error("index register changed");
   cov_mul_c: cover property (@(posedge ref_clk)
      state == MUL ##1 state == IDLE);
   cov_div_c: cover property (@(posedge ref_clk)
      state == DIV ##1 state == IDLE);
   cov_shift_c: cover property (@(posedge ref_clk)
      shifting && shift_op == OP_SHL_AQ);
endmodule
`default_nettype wire

// File: cpu_register_datapath_tb.sv
// Self-checking bench for the register datapath.
// Assumes the storage model answers a read within the strobe cycle.
`timescale 1ns/1ns
`default_nettype none
module cpu_register_datapath_tb;
   import datapath_pkg::*;
   typedef struct {int sel; logic [WORD_W-1:0] val;} note_type;
   logic              ref_clk, rst_n, cmd_valid, instr_load, modify_en;
   logic              read_strobe, write_strobe, chan_in_valid, busy;
   logic              periph_out_load, intercomp_out_load, cmd_ready;
   command_type       cmd;
   visible_type       visible;
   logic [WORD_W-1:0] instr_word, sense_data, chan_in_data, write_data;
   logic [WORD_W-1:0] pob, iob, a, q, d, r;
   logic [ADDR_W-1:0] storage_addr, pc, y, x;
   logic [ADDR_W:0]   s;
   logic [59:0]       aq;
   logic [STEP_W-1:0] c, ec;
   logic [OP_W-1:0]   sop [6];
   note_type          notes [$];
   note_type          cur;
   int                num_errors, tests_run, seed, n;
   ////////////////////////////////////////////////////////////////////////
   cpu_register_datapath cpu_register_datapath_inst (
      .ref_clk, .rst_n, .cmd_valid, .cmd, .cmd_ready, .busy, .instr_load,
      .instr_word, .modify_en, .read_strobe, .sense_data, .write_strobe,
      .storage_addr, .write_data, .chan_in_valid, .chan_in_data,
      .periph_out_load, .intercomp_out_load, .visible,
      .peripheral_output_buffer(pob), .intercomputer_output_buffer(iob));
   storage_model storage_model_inst (.ref_clk, .read_strobe,
      .write_strobe, .storage_addr, .write_data, .sense_data);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [WORD_W-1:0] seen, want);
      tests_run++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t ns: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic note(input int sel, input logic [WORD_W-1:0] val);
      notes.push_back('{sel, val});
   endtask
   task automatic tick;
      @(negedge ref_clk);
   endtask
   task automatic fetch(input logic [2:0] b, input logic [ADDR_W-1:0] ya);
      instr_word = {12'h000, b, ya};
      instr_load = 1'b1;
      tick;
      instr_load = 1'b0;
      pc = pc + ADDR_ONE;
   endtask
   // Words reach storage through the input channel and the write-back path
   task automatic put(input logic [ADDR_W-1:0] ya, input logic [29:0] w);
      fetch(3'h0, ya);
      chan_in_data = w;
      chan_in_valid = 1'b1;
      tick;
      chan_in_valid = 1'b0;
      write_strobe = 1'b1;
      note(6, w);
      tick;
      write_strobe = 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] ya);
      fetch(3'h0, ya);
      note(3, WORD_W'(ya));
      read_strobe = 1'b1;
      tick;
      read_strobe = 1'b0;
   endtask
   task automatic run(input logic [OP_W-1:0] op, input logic [5:0] cnt,
                      input logic [2:0] sel, input logic [14:0] ja,
                      input logic jmp);
      cmd = '{op, cnt, sel, ja, jmp};
      cmd_valid = 1'b1;
      tick;
      cmd_valid = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         n++;
         tick;
      end
      if (n == 100) begin
         num_errors++;
         $display("unexpected at %0t ns: busy never fell", $time);
         end_of_test;
      end
      tick;
   endtask
   task automatic op_mem(input logic [OP_W-1:0] op, input logic [14:0] ya);
      rd(ya);
      run(op, 6'h00, 3'h0, ADDR_ZERO, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watcher: values seen at an edge are those settled before it
   always @(posedge ref_clk) begin
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         case (cur.sel)
            0: r = visible.double_hi;
            1: r = visible.double_lo;
            2: r = WORD_W'(visible.program_addr);
            3: r = WORD_W'(storage_addr);
            4: r = pob;
            5: r = iob;
            default: r = write_data;
         endcase
         check(r, cur.val);
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      {rst_n, cmd_valid, instr_load, modify_en, read_strobe} = '0;
      {write_strobe, chan_in_valid, periph_out_load, intercomp_out_load} = '0;
      {cmd, instr_word, chan_in_data, pc} = '0;
      {num_errors, tests_run} = '0;
      seed = 78113;
      sop = '{OP_SHL_A, OP_SHR_A, OP_SHL_AQ, OP_SHR_AQ, OP_SHL_Q, OP_SHR_Q};
      repeat (8) @(posedge ref_clk);
      tick;
      rst_n = 1'b1;
      note(0, WORD_ZERO);
      note(2, WORD_ZERO);
      note(5, WORD_ZERO);
      check(WORD_W'(cmd_ready), 30'h00000001);
      a = $random(seed);
      d = $random(seed);
      q = $random(seed);
      put(15'h0100, a);
      put(15'h0101, d);
      put(15'h0102, q);
      op_mem(OP_LOAD_A, 15'h0100);
      note(0, a);
      op_mem(OP_ADD, 15'h0101);
      note(0, a + d);
      op_mem(OP_SUB, 15'h0100);
      note(0, d);
      note(2, WORD_W'(pc));
      op_mem(OP_LOAD_Q, 15'h0102);
      op_mem(OP_ADD_Q, 15'h0101);
      q = q + d;
      note(1, q);
      op_mem(OP_AND_Q, 15'h0100);
      q = q & a;
      note(1, q);
      $display("test arithmetic finished");
      op_mem(OP_MUL, 15'h0100);
      check(WORD_W'(n), 30'h0000001E);
      aq = a * q;
      note(0, aq[59:30]);
      note(1, aq[29:0]);
      // Dividend high half kept below the divisor so the quotient fits
      {a, q, d} = {$random(seed), $random(seed), $random(seed)};
      a[29:28] = 2'b00;
      d[29] = 1'b1;
      put(15'h0103, a);
      put(15'h0104, q);
      put(15'h0105, d);
      op_mem(OP_LOAD_A, 15'h0103);
      op_mem(OP_LOAD_Q, 15'h0104);
      op_mem(OP_DIV, 15'h0105);
      check(WORD_W'(n), 30'h0000001E);
      aq = {a, q};
      a = aq % d;
      q = aq / d;
      note(0, a);
      note(1, q);
      $display("test multiply and divide finished");
      for (int i = 0; i < 6; i++) begin
         c = (i == 5) ? 6'h3F : 6'($random(seed));
         ec = (c > SHIFT_MAX) ? SHIFT_MAX : c;
         run(sop[i], c, 3'h0, ADDR_ZERO, 1'b0);
         aq = {a, q};
         case (sop[i])
            OP_SHL_A: a = a << ec;
            OP_SHR_A: a = $signed(a) >>> ec;
            OP_SHL_AQ: aq = aq << ec;
            OP_SHR_AQ: aq = $signed(aq) >>> ec;
            OP_SHL_Q: q = q << ec;
            default: q = $signed(q) >>> ec;
         endcase
         if (sop[i] == OP_SHL_AQ || sop[i] == OP_SHR_AQ)
            {a, q} = aq;
         note(0, a);
         note(1, q);
         check(WORD_W'(n), WORD_W'(ec));
      end
      $display("test shifts finished");
      for (int i = 0; i < 8; i++) begin
         x = (i == 7) ? ADDR_ONE : 15'($random(seed));
         y = (i == 7) ? 15'h7FFF : 15'($random(seed));
         run(OP_LOAD_IDX, 6'h00, 3'(i), x, 1'b0);
         if (i == 0)
            x = ADDR_ZERO;
         fetch(3'(i), y);
         modify_en = 1'b1;
         tick;
         modify_en = 1'b0;
         s = y + x;
         s = s[ADDR_W-1:0] + s[ADDR_W];
         note(3, WORD_W'(s[ADDR_W-1:0]));
      end
      $display("test index modification finished");
      run(OP_NOP, 6'h00, 3'h0, 15'h2468, 1'b1);
      pc = 15'h2468;
      note(2, WORD_W'(pc));
      rd(15'h0105);
      periph_out_load = 1'b1;
      tick;
      periph_out_load = 1'b0;
      note(4, d);
      put(15'h0106, a);
      rd(15'h0106);
      intercomp_out_load = 1'b1;
      tick;
      intercomp_out_load = 1'b0;
      note(5, a);
      note(2, WORD_W'(pc));
      tick;
      $display("test jump and output buffers finished");
      end_of_test;
   end
endmodule
`default_nettype wire

// File: datapath_pkg.sv
// Shared constants and carrier types for the register datapath.
// Assumes a single 250 MHz clock domain and no software register bus.
package datapath_pkg;

   localparam int WORD_W     = 30;
   localparam int ADDR_W     = 15;
   localparam int STEP_W     = 6;
   localparam int INDEX_N    = 7;
   localparam int SEL_W      = 3;
   localparam int OP_W       = 4;

   localparam logic [STEP_W-1:0] MULDIV_PRESET = 6'h1E;
   localparam logic [STEP_W-1:0] SHIFT_MAX     = 6'h3B;

   localparam int FIELD_Y_LO = 0;
   localparam int FIELD_Y_HI = 14;
   localparam int FIELD_B_LO = 15;
   localparam int FIELD_B_HI = 17;

   localparam logic [WORD_W-1:0] WORD_ZERO = 30'h00000000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE  = 15'h0001;

   localparam int PERIPH_CHANNELS = 12;
   localparam int INTERCOMP_CHANNELS = 2;

   // Operation codes accepted on the command port
   localparam logic [OP_W-1:0] OP_NOP      = 4'h0;
   localparam logic [OP_W-1:0] OP_ADD      = 4'h1;
   localparam logic [OP_W-1:0] OP_SUB      = 4'h2;
   localparam logic [OP_W-1:0] OP_LOAD_A   = 4'h3;
   localparam logic [OP_W-1:0] OP_LOAD_Q   = 4'h4;
   localparam logic [OP_W-1:0] OP_ADD_Q    = 4'h5;
   localparam logic [OP_W-1:0] OP_AND_Q    = 4'h6;
   localparam logic [OP_W-1:0] OP_MUL      = 4'h7;
   localparam logic [OP_W-1:0] OP_DIV      = 4'h8;
   localparam logic [OP_W-1:0] OP_SHL_A    = 4'h9;
   localparam logic [OP_W-1:0] OP_SHR_A    = 4'hA;
   localparam logic [OP_W-1:0] OP_SHL_AQ   = 4'hB;
   localparam logic [OP_W-1:0] OP_SHR_AQ   = 4'hC;
   localparam logic [OP_W-1:0] OP_LOAD_IDX = 4'hD;
   localparam logic [OP_W-1:0] OP_SHL_Q    = 4'hE;
   localparam logic [OP_W-1:0] OP_SHR_Q    = 4'hF;

   typedef struct packed {
      logic [OP_W-1:0]   op;
      logic [STEP_W-1:0] count;
      logic [SEL_W-1:0]  index_sel;
      logic [ADDR_W-1:0] jump_addr;
      logic              jump;
   } command_type;

   typedef struct packed {
      logic [WORD_W-1:0] double_hi;
      logic [WORD_W-1:0] double_lo;
      logic [ADDR_W-1:0] program_addr;
   } visible_type;

endpackage

// File: end_around_adder.sv
// Fifteen-bit ones' complement adder with end-around carry.
// Pure combinational; used for operand address modification.
`timescale 1ns/1ns
`default_nettype none
module end_around_adder
   import datapath_pkg::*;
(
   // Operands
   input  wire logic [ADDR_W-1:0] base,
   input  wire logic [ADDR_W-1:0] increment,
   // Result
   output logic      [ADDR_W-1:0] sum
);
   logic [ADDR_W:0] raw;

   always_comb begin
      raw = {1'b0, base} + {1'b0, increment};
      // Carry out re-enters the low bit
      sum = raw[ADDR_W-1:0] + {{(ADDR_W-1){1'b0}}, raw[ADDR_W]};
   end
endmodule
`default_nettype wire

// File: step_counter.sv
// Six-bit shift step counter, counting down from a preset.
// Assumes load and step are never asserted together by the sequencer.
`timescale 1ns/1ns
`default_nettype none
module step_counter
   import datapath_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // Control
   input  wire logic              load,
   input  wire logic [STEP_W-1:0] preset,
   input  wire logic              step,
   // State
   output logic      [STEP_W-1:0] count,
   output logic                   done
);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         // Requests beyond the limit are clipped, never wrapped
         count <= (preset > SHIFT_MAX) ? SHIFT_MAX : preset;
      end else if (step && count != '0) begin
         count <= count - 6'h01;
      end
   end

   assign done = (count == '0);
endmodule
`default_nettype wire

// File: storage_model.sv
// Behavioural core storage facing the datapath storage port.
// Assumes the bench pulses the strobes and the datapath holds the address.
`timescale 1ns/1ns
`default_nettype none
module storage_model
   import datapath_pkg::*;
(
   // Clock
   input  wire logic              ref_clk,
   // Access
   input  wire logic              read_strobe,
   input  wire logic              write_strobe,
   input  wire logic [ADDR_W-1:0] storage_addr,
   input  wire logic [WORD_W-1:0] write_data,
   output logic      [WORD_W-1:0] sense_data
);
   logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [WORD_W-1:0] last = WORD_ZERO;
   ////////////////////////////////////////////////////////////////////////
   // Sense lines toggle outside a read so stale data never looks valid
   always @* begin
      if (read_strobe)
         sense_data = mem[storage_addr];
      else
         sense_data = ~last;
   end
   always @(posedge ref_clk) begin
      last <= sense_data;
      if (write_strobe)
         mem[storage_addr] <= write_data;
   end
endmodule
`default_nettype wire
